/* pmuisc_map.vh */
// register map and constants for the pmu interrupt, status and comparator block
`ifndef PMUISC_MAP_VH
`define PMUISC_MAP_VH
`define PMUISC_ADDR_W 8
`define PMUISC_DATA_W 8
`define PMUISC_REG_CMP_CTRL 8'h0b
`define PMUISC_REG_IRQ_MASK 8'h0c
`define PMUISC_REG_IRQ_FLAGS 8'h0d
`define PMUISC_REG_CTRL 8'h0e
`define PMUISC_REG_CMP_THR 8'h0f
`define PMUISC_MASK_RST 8'h00
`define PMUISC_CTRL_RST 8'h00
`define PMUISC_CMPCTRL_RST 8'h00
`define PMUISC_THR_RST 8'h19
// millivolt constants are sized to the 16 bit compare width of the top module
`define PMUISC_THR_STEP_MV 16'h001f
`define PMUISC_THR_BASE_MV 16'h07d0
`define PMUISC_HYST_MV 16'h003c
`define PMUISC_CTRL_POL_BIT 0
`define PMUISC_CMPCTRL_HYST2_BIT 0
`define PMUISC_NSRC 5
`define PMUISC_SRC_B1 0
`define PMUISC_SRC_B2 1
`define PMUISC_SRC_B3 2
`define PMUISC_SRC_LIN 3
`define PMUISC_SRC_CMP 4
// percentages: 90 rising, 85 falling, 100 full scale
`define PMUISC_RISE_PCT 7'h5a
`define PMUISC_FALL_PCT 7'h55
`define PMUISC_PCT_FULL 7'h64
`define PMUISC_MV_W 13
`endif

/* pmuisc_regs.v */
// small register store holding the writable control words
`timescale 1ns/1ps
`default_nettype none
`include "pmuisc_map.vh"
module pmuisc_regs (
  input wire i_clk,
  input wire i_rst,
  input wire i_wr,
  input wire [1:0] i_sel,
  input wire [7:0] i_wdata,
  output reg [7:0] o_mask,
  output reg [7:0] o_ctrl,
  output reg [7:0] o_cmp_ctrl,
  output reg [7:0] o_thr
);
  // =====================================================
  // storage; reset here also models overheat restoring defaults
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mask <= `PMUISC_MASK_RST;
      o_ctrl <= `PMUISC_CTRL_RST;
      o_cmp_ctrl <= `PMUISC_CMPCTRL_RST;
      o_thr <= `PMUISC_THR_RST;
    end else if (i_wr) begin
      case (i_sel)
        2'h0: o_mask <= i_wdata;
        2'h1: o_ctrl <= i_wdata;
        2'h2: o_cmp_ctrl <= i_wdata;
        default: o_thr <= i_wdata;
      endcase
    end
  end
endmodule // pmuisc_regs
`default_nettype wire

/* pmuisc_top.v */
// interrupt, live status and voltage comparator logic of the power unit
`timescale 1ns/1ps
`default_nettype none
`include "pmuisc_map.vh"
module pmuisc_top #(
  parameter MV_W = `PMUISC_MV_W
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_die_overheat_shutdown,
  input wire [MV_W-1:0] i_monitored_voltage_input,
  input wire [MV_W-1:0] i_reg_mv_b1,
  input wire [MV_W-1:0] i_reg_mv_b2,
  input wire [MV_W-1:0] i_reg_mv_b3,
  input wire [MV_W-1:0] i_linear_regulator_mv,
  input wire [MV_W-1:0] i_tgt_mv_b1,
  input wire [MV_W-1:0] i_tgt_mv_b2,
  input wire [MV_W-1:0] i_tgt_mv_b3,
  input wire [MV_W-1:0] i_linear_regulator_tgt_mv,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  output reg o_irq,
  output wire o_in_reset
);
  // =====================================================
  // reset and overheat
  // overheat is folded into the reset net, so every register here and in the store
  // returns to its default and stays there for as long as the die is too hot
  wire blk_rst;
  assign blk_rst = i_rst | i_die_overheat_shutdown;
  assign o_in_reset = blk_rst;

  // =====================================================
  // local constants
  // millivolt sums run at this width; the top threshold code lands near 9.9 volts,
  // which the 13 bit inputs cannot hold, so nothing is compared at the input width
  localparam CMP_W = 16;
  // register indices handed out by the address decode
  localparam [2:0] IDX_MASK = 3'h0;
  localparam [2:0] IDX_CTRL = 3'h1;
  localparam [2:0] IDX_CMPC = 3'h2;
  localparam [2:0] IDX_THR = 3'h3;
  localparam [2:0] IDX_FLAGS = 3'h4;
  localparam [2:0] IDX_NONE = 3'h7;

  // =====================================================
  // shared decode and arithmetic
  // one decode for writes and reads, so the two paths cannot disagree on the map
  function [2:0] reg_index;
    input [7:0] a;
    begin
      case (a)
        `PMUISC_REG_IRQ_MASK: reg_index = IDX_MASK;
        `PMUISC_REG_CTRL: reg_index = IDX_CTRL;
        `PMUISC_REG_CMP_CTRL: reg_index = IDX_CMPC;
        `PMUISC_REG_CMP_THR: reg_index = IDX_THR;
        `PMUISC_REG_IRQ_FLAGS: reg_index = IDX_FLAGS;
        default: reg_index = IDX_NONE;
      endcase
    end
  endfunction

  // zero extension to the compare width; MV_W must stay below CMP_W
  function [CMP_W-1:0] widen;
    input [MV_W-1:0] v;
    begin
      widen = {{(CMP_W-MV_W){1'b0}}, v};
    end
  endfunction

  // value times percentage; the product is wide enough that it never wraps
  function [MV_W+6:0] scale;
    input [MV_W-1:0] v;
    input [6:0] pct;
    begin
      scale = v * pct;
    end
  endfunction

  // threshold code to millivolts; codes past the top of the range are not clamped,
  // they only give a threshold that the monitored input never reaches
  function [CMP_W-1:0] thr_code_mv;
    input [7:0] code;
    begin
      thr_code_mv = `PMUISC_THR_BASE_MV + {8'h00, code} * `PMUISC_THR_STEP_MV;
    end
  endfunction

  // regulator good flag: sets above the rising level, clears below the falling level
  function upd_flag;
    input cur;
    input [MV_W-1:0] v;
    input [MV_W-1:0] t;
    begin
      if (scale(v, `PMUISC_PCT_FULL) > scale(t, `PMUISC_RISE_PCT))
        upd_flag = 1'b1;
      else if (scale(v, `PMUISC_PCT_FULL) < scale(t, `PMUISC_FALL_PCT))
        upd_flag = 1'b0;
      else
        upd_flag = cur;
    end
  endfunction

  // comparator flag: sets above the threshold, clears only once the input has fallen
  // a full hysteresis step below it, so a slowly falling input does not chatter
  function cmp_next;
    input cur;
    input [CMP_W-1:0] v;
    input [CMP_W-1:0] thr;
    input [CMP_W-1:0] hyst;
    begin
      if (v > thr)
        cmp_next = 1'b1;
      else if (v + hyst < thr)
        cmp_next = 1'b0;
      else
        cmp_next = cur;
    end
  endfunction

  // =====================================================
  // register store
  wire [7:0] mask_w;
  wire [7:0] ctrl_w;
  wire [7:0] cmpc_w;
  wire [7:0] thr_w;
  reg wr_hit;
  reg [1:0] wr_sel;
  // writes to the flag register or to unmapped addresses fall through and are dropped
  always @* begin
    wr_hit = 1'b0;
    wr_sel = 2'h0;
    case (reg_index(i_addr))
      IDX_MASK: begin
        wr_hit = i_wr;
        wr_sel = 2'h0;
      end
      IDX_CTRL: begin
        wr_hit = i_wr;
        wr_sel = 2'h1;
      end
      IDX_CMPC: begin
        wr_hit = i_wr;
        wr_sel = 2'h2;
      end
      IDX_THR: begin
        wr_hit = i_wr;
        wr_sel = 2'h3;
      end
      default: begin
        wr_hit = 1'b0;
        wr_sel = 2'h0;
      end
    endcase
  end
  pmuisc_regs u_regs (
    .i_clk(i_clk),
    .i_rst(blk_rst),
    .i_wr(wr_hit),
    .i_sel(wr_sel),
    .i_wdata(i_wdata),
    .o_mask(mask_w),
    .o_ctrl(ctrl_w),
    .o_cmp_ctrl(cmpc_w),
    .o_thr(thr_w)
  );

  // =====================================================
  // regulator and comparator flags
  reg [`PMUISC_NSRC-1:0] flags_q;
  wire [CMP_W-1:0] thr_mv;
  wire [CMP_W-1:0] hyst_mv;
  assign thr_mv = thr_code_mv(thr_w);
  // hysteresis only widens the falling side; the rising trip point stays at the threshold
  assign hyst_mv = cmpc_w[`PMUISC_CMPCTRL_HYST2_BIT] ?
    (`PMUISC_HYST_MV << 1) : `PMUISC_HYST_MV;
  always @(posedge i_clk or posedge blk_rst) begin
    if (blk_rst) begin
      flags_q <= {`PMUISC_NSRC{1'b0}};
    end else begin
      flags_q[`PMUISC_SRC_B1] <= upd_flag(flags_q[`PMUISC_SRC_B1], i_reg_mv_b1, i_tgt_mv_b1);
      flags_q[`PMUISC_SRC_B2] <= upd_flag(flags_q[`PMUISC_SRC_B2], i_reg_mv_b2, i_tgt_mv_b2);
      flags_q[`PMUISC_SRC_B3] <= upd_flag(flags_q[`PMUISC_SRC_B3], i_reg_mv_b3, i_tgt_mv_b3);
      flags_q[`PMUISC_SRC_LIN] <= upd_flag(flags_q[`PMUISC_SRC_LIN], i_linear_regulator_mv,
        i_linear_regulator_tgt_mv);
      // comparator: above threshold sets, below threshold minus hysteresis clears
      flags_q[`PMUISC_SRC_CMP] <= cmp_next(flags_q[`PMUISC_SRC_CMP],
        widen(i_monitored_voltage_input), thr_mv, hyst_mv);
    end
  end

  // =====================================================
  // irq pin: or of enabled live flags, polarity from control bit
  // the pin is registered so that it cannot glitch while several flags change together
  wire irq_act;
  assign irq_act = |(flags_q & mask_w[`PMUISC_NSRC-1:0]);
  always @(posedge i_clk or posedge blk_rst) begin
    if (blk_rst)
      o_irq <= 1'b1; // inactive level under default active-low polarity
    else
      o_irq <= ctrl_w[`PMUISC_CTRL_POL_BIT] ? irq_act : ~irq_act;
  end

  // =====================================================
  // read path; reads have no side effects
  // read data follow the address every cycle; only o_rvalid marks a requested read
  always @(posedge i_clk or posedge blk_rst) begin
    if (blk_rst) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      case (reg_index(i_addr))
        IDX_MASK: o_rdata <= mask_w;
        IDX_FLAGS: o_rdata <= {3'h0, flags_q};
        IDX_CTRL: o_rdata <= ctrl_w;
        IDX_CMPC: o_rdata <= cmpc_w;
        IDX_THR: o_rdata <= thr_w;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule // pmuisc_top
`default_nettype wire

/* pmuisc_checker.sv */
// port assertions for the interrupt, status and comparator block
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module pmuisc_checker #(parameter MV_W = 13) (
  input wire i_clk,
  input wire i_rst,
  input wire i_die_overheat_shutdown,
  input wire [MV_W-1:0] i_reg_mv_b1,
  input wire [MV_W-1:0] i_tgt_mv_b1,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] o_rdata,
  input wire o_rvalid,
  input wire o_irq,
  input wire o_in_reset
);
  wire rf = i_rd && i_addr == 8'h0d;
  wire hi = i_reg_mv_b1 * 100 > i_tgt_mv_b1 * 90;
  wire lo = i_reg_mv_b1 * 100 < i_tgt_mv_b1 * 85;
  wire um = i_rd && (i_addr < 8'h0b || i_addr > 8'h0f);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || i_die_overheat_shutdown);
  a_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read not answered");
  a_rvalid_pulse: assert property (!i_rd |=> !o_rvalid)
    else $error("stray read valid");
  a_unmapped_zero: assert property (um |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flags_top_zero: assert property (rf |=> o_rdata[7:5] == 3'h0)
    else $error("spare flag bits set");
  a_flag_rise: assert property (rf && hi && $past(hi) && !$past(o_in_reset) |=> o_rdata[0])
    else $error("regulator flag not set");
  a_flag_fall: assert property (rf && lo && $past(lo) |=> !o_rdata[0])
    else $error("regulator flag not cleared");
  a_heat_reset: assert property (disable iff (i_rst) i_die_overheat_shutdown |-> o_in_reset)
    else $error("overheat not in reset");
  a_heat_irq: assert property (disable iff (i_rst) i_die_overheat_shutdown |-> o_irq)
    else $error("irq active in overheat");
endmodule // pmuisc_checker
bind pmuisc_top pmuisc_checker #(.MV_W(MV_W)) u_chk (.i_clk, .i_rst, .i_die_overheat_shutdown,
  .i_reg_mv_b1, .i_tgt_mv_b1, .i_rd, .i_addr, .o_rdata, .o_rvalid, .o_irq, .o_in_reset);
`default_nettype wire

/* pmuisc_host.sv */
// host model reaching the registers by strobes
`timescale 1ns/1ps
`default_nettype none
// ====
// host
module pmuisc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // one idle cycle between strobes keeps each strobe a clean pulse
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk) #1 {o_wr, o_addr, o_wdata} = {1'b1, a, v};
    @(posedge i_clk) #1 o_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk) #1 {o_rd, o_addr} = {1'b1, a};
    @(posedge i_clk) #1 o_rd = 1'b0;
    v = i_rdata;
  endtask
endmodule // pmuisc_host
`default_nettype wire

/* tb_pmu_interrupt_status_comparator.sv */
// self-checking bench for the interrupt, status and comparator block
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module tb_pmu_interrupt_status_comparator;
  logic clk = 0, rst = 1, heat = 0;
  logic [12:0] vm = 13'h0000, vb = 13'h0000, tg = 13'h03e8;
  wire wr, rd, rv, irq, inr;
  wire [7:0] ad, wd, rdat;
  logic [7:0] d;
  int n_errors = 0, n_checks = 0;
  pmuisc_host h (.i_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_addr(ad), .o_wdata(wd));
  pmuisc_top dut (.i_clk(clk), .i_rst(rst), .i_die_overheat_shutdown(heat),
    .i_monitored_voltage_input(vm), .i_reg_mv_b1(vb), .i_reg_mv_b2(vb), .i_reg_mv_b3(vb),
    .i_linear_regulator_mv(vb), .i_tgt_mv_b1(tg), .i_tgt_mv_b2(tg), .i_tgt_mv_b3(tg),
    .i_linear_regulator_tgt_mv(tg), .i_wr(wr), .i_rd(rd), .i_addr(ad), .i_wdata(wd),
    .o_rdata(rdat), .o_rvalid(rv), .o_irq(irq), .o_in_reset(inr));
  initial forever #2 clk = ~clk;
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d);
    chk("rdata", d, e);
    chk("rvalid", rv, 8'h01);
  endtask
  task s3;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_def;
    rc(8'h0f, 8'h19);
    rc(8'h0e, 8'h00);
    rc(8'h0c, 8'h00);
    rc(8'h0b, 8'h00);
    rc(8'h0a, 8'h00);
    h.wr(8'h0d, 8'hff);
    rc(8'h0d, 8'h00);
    chk("irq", irq, 8'h01);
  endtask
  task t_reg;
    h.wr(8'h0c, 8'h1f);
    vb = 13'h03b6;
    s3;
    rc(8'h0d, 8'h0f);
    chk("irq", irq, 8'h00);
    rc(8'h0d, 8'h0f);
    vb = 13'h0366;
    s3;
    rc(8'h0d, 8'h0f);
    vb = 13'h0348;
    s3;
    rc(8'h0d, 8'h00);
    chk("irq", irq, 8'h01);
  endtask
  task t_cmp;
    vm = 13'h0af0;
    s3;
    rc(8'h0d, 8'h10);
    chk("irq", irq, 8'h00);
    h.wr(8'h0e, 8'h01);
    s3;
    chk("irq", irq, 8'h01);
    vm = 13'h0ab4;
    s3;
    rc(8'h0d, 8'h10);
    vm = 13'h0a8c;
    s3;
    rc(8'h0d, 8'h00);
    chk("irq", irq, 8'h00);
    h.wr(8'h0b, 8'h01);
    vm = 13'h0af0;
    s3;
    vm = 13'h0a8c;
    s3;
    rc(8'h0d, 8'h10);
  endtask
  task t_msk;
    h.wr(8'h0c, 8'h00);
    s3;
    chk("irq", irq, 8'h00);
    rc(8'h0d, 8'h10);
    h.wr(8'h0c, 8'h10);
    s3;
    chk("irq", irq, 8'h01);
  endtask
  task t_heat;
    vm = 13'h0000;
    h.wr(8'h0f, 8'h20);
    rc(8'h0f, 8'h20);
    vm = 13'h0b54;
    s3;
    rc(8'h0d, 8'h00);
    vm = 13'h0bb8;
    s3;
    rc(8'h0d, 8'h10);
    vm = 13'h0000;
    s3;
    chk("irq", irq, 8'h00);
    @(posedge clk) #1 heat = 1;
    #1 chk("irq", irq, 8'h01);
    chk("in_reset", inr, 8'h01);
    @(posedge clk) #1 heat = 0;
    #1 chk("in_reset", inr, 8'h00);
    chk("irq", irq, 8'h01);
    rc(8'h0c, 8'h00);
    rc(8'h0e, 8'h00);
    rc(8'h0b, 8'h00);
    rc(8'h0f, 8'h19);
  endtask
  task conclude;
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    t_def;
    t_reg;
    t_cmp;
    t_msk;
    t_heat;
    conclude;
  end
endmodule // tb_pmu_interrupt_status_comparator
`default_nettype wire
